/* File: logic/icu_pkg.sv */
// shared constants and carrier types for the cascaded interrupt control unit
package icu_pkg;

   // ----------------------------------------------------------------
   // request line counts
   // ----------------------------------------------------------------
   localparam int EXT_N  = 8;              // external request pins
   localparam int INT_N  = 8;              // internal peripheral lines
   localparam int CASC_N = 4;              // low pins that may carry a cascaded controller
   localparam int MST_N  = EXT_N + 1;      // master sees the pins plus the slave
   localparam int MST_BW = $clog2(MST_N);  // master index width
   localparam int SLV_BW = $clog2(INT_N);  // slave index width

   // slave request enters the master at the lowest-priority slot by default
   localparam logic [MST_BW-1:0] SLAVE_IDX = 4'h8;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   // per-controller setup written by software
   typedef struct packed {
      logic       edge_mode;  // 1: rising edge, 0: active-high level
      logic [2:0] prio_base;  // line that currently holds top priority
   } ctrl_cfg_t;

   // identity of the request handed to the core at acknowledge
   typedef struct packed {
      logic       from_slave; // 1: internal line, 0: external pin
      logic [2:0] line;       // line number inside that controller
   } irq_vector_t;

   localparam ctrl_cfg_t   CFG_DEFAULT = '{edge_mode: 1'b0, prio_base: 3'h0};
   localparam irq_vector_t VEC_NONE    = '{from_slave: 1'b0, line: 3'h0};

endpackage

/* File: logic/prio_resolver.sv */
// one priority-resolving request controller: pending latch and rotating resolver
module prio_resolver #(
   parameter int N = 8
) (
   input  wire logic                 clk,         // peripheral clock
   input  wire logic                 reset,       // synchronous, active high
   input  wire logic [N-1:0]         req_in,      // request levels, same clock
   input  wire logic                 edge_mode,   // 1: rising edge recognition
   input  wire logic [N-1:0]         force_level, // lines always level sensitive
   input  wire logic [$clog2(N)-1:0] base,        // top-priority line
   input  wire logic                 ack,         // clear the selected request
   output logic      [N-1:0]         pend_r,      // pending-request bits
   output logic                      any_r,       // some request selected
   output logic      [$clog2(N)-1:0] sel_r        // selected line
);

   localparam int BW = $clog2(N);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (N < 2 || N > 16) begin : g_bad_n
      $error("prio_resolver: N must lie in 2..16");
   end

   // ----------------------------------------------------------------
   // resolver: first pending line walking from base upward, wrapping
   // ----------------------------------------------------------------
   function automatic logic [BW:0] resolve(input logic [N-1:0] p, input logic [BW-1:0] b);
      logic [BW:0] r;
      int          idx;
      r = '0;
      for (int k = N - 1; k >= 0; k--) begin
         idx = (int'(b) + k) % N;
         if (p[idx]) begin
            r = {1'b1, BW'(idx)};
         end
      end
      return r;
   endfunction

   logic [N-1:0]  prev_r, prev_nxt, pend_nxt;
   logic          any_nxt;
   logic [BW-1:0] sel_nxt;
   logic [BW:0]   res;

   // pending bits; a new edge wins over an acknowledge clear in the same cycle
   always_comb begin
      prev_nxt = req_in;
      for (int i = 0; i < N; i++) begin
         if (!edge_mode || force_level[i]) begin
            pend_nxt[i] = req_in[i];
         end else begin
            pend_nxt[i] = (req_in[i] & ~prev_r[i])
                        | (pend_r[i] & ~(ack && any_r && sel_r == BW'(i)));
         end
      end
      res     = resolve(pend_r, base);
      any_nxt = res[BW];
      sel_nxt = res[BW-1:0];
   end

   // registers, all cleared on chip reset
   always_ff @(posedge clk) begin
      if (reset) begin
         prev_r <= '0;
         pend_r <= '0;
         any_r  <= 1'b0;
         sel_r  <= '0;
      end else begin
         prev_r <= prev_nxt;
         pend_r <= pend_nxt;
         any_r  <= any_nxt;
         sel_r  <= sel_nxt;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic [N-1:0] pend_q;
   always_ff @(posedge clk) begin
      pend_q <= pend_r;
   end

   property p_sel_was_pending;
      any_r |-> pend_q[sel_r];
   endproperty
   a_sel_was_pending: assert property (p_sel_was_pending) else $error("selected line was not pending");

   property p_edge_needs_rise;
      (edge_mode && force_level == '0 && req_in == prev_r && pend_r == '0) |=> pend_r == '0;
   endproperty
   a_edge_needs_rise: assert property (p_edge_needs_rise) else $error("edge mode latched without a rise");

endmodule

/* File: logic/irq_control_unit.sv */
// cascaded interrupt control unit: master and slave resolvers, pin sync, core handshake
// Summary of operation
// - the unit is two priority resolvers, a master and a slave, the slave feeding one master input.
// - eight external pins and eight internal lines are accepted as requests.
// - each request line owns a pending bit that follows its level, or in edge mode, except on cascaded pins, is set on a rise and held until acknowledged.
// - each controller is set to recognise active-high levels or rising edges.
// - among several pending requests the resolver picks the one with top priority in the current order.
// - the resolver drives one request line to the core while a request is selected.
// - after reset line zero has top priority and line seven the lowest, with the slave input below pin seven on the master.
// - software writes may move the priority order away from the default.
// - up to four external controllers hang on the four lowest pins.
module irq_control_unit (
   input  wire logic                       clk,                // peripheral clock, 20 MHz
   input  wire logic                       reset,              // synchronous, active high
   input  wire logic [icu_pkg::EXT_N-1:0]  ext_irq_pins,       // external request pins, asynchronous
   input  wire logic [icu_pkg::INT_N-1:0]  internal_irq_lines, // peripheral requests, same clock
   input  wire logic [icu_pkg::CASC_N-1:0] cascade_en,         // pins carrying an external controller
   input  wire logic                       cfg_wr,             // software write strobe
   input  wire icu_pkg::ctrl_cfg_t         master_cfg_in,      // master setup to write
   input  wire icu_pkg::ctrl_cfg_t         slave_cfg_in,       // slave setup to write
   input  wire logic                       irq_ack,            // core acknowledge pulse
   output icu_pkg::ctrl_cfg_t              master_cfg_r,       // master setup in force
   output icu_pkg::ctrl_cfg_t              slave_cfg_r,        // slave setup in force
   output logic                            irq_to_core_r,      // interrupt request to core
   output logic                            ack_valid_r,        // vector valid, one cycle
   output icu_pkg::irq_vector_t            ack_vector_r,       // acknowledged request
   output logic [icu_pkg::CASC_N-1:0]      casc_active_r       // external controller being served
);

   localparam int EN  = icu_pkg::EXT_N;
   localparam int MN  = icu_pkg::MST_N;
   localparam int MBW = icu_pkg::MST_BW;
   localparam int SBW = icu_pkg::SLV_BW;
   localparam int CN  = icu_pkg::CASC_N;

   // ----------------------------------------------------------------
   // pin synchroniser: three stages, change taken once stages 2 and 3 agree
   // ----------------------------------------------------------------
   logic [EN-1:0] s1_r, s2_r, s3_r, ext_filt_r;
   logic [EN-1:0] ext_filt_nxt;

   // filter keeps the old value while the last two stages still disagree
   always_comb begin
      for (int i = 0; i < EN; i++) begin
         ext_filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : ext_filt_r[i];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s1_r       <= '0;
         s2_r       <= '0;
         s3_r       <= '0;
         ext_filt_r <= '0;
      end else begin
         s1_r       <= ext_irq_pins;
         s2_r       <= s1_r;
         s3_r       <= s2_r;
         ext_filt_r <= ext_filt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // software setup registers
   // ----------------------------------------------------------------
   icu_pkg::ctrl_cfg_t master_cfg_nxt, slave_cfg_nxt;

   // a write replaces both setups at once; reset restores the fixed order
   always_comb begin
      master_cfg_nxt = cfg_wr ? master_cfg_in : master_cfg_r;
      slave_cfg_nxt  = cfg_wr ? slave_cfg_in  : slave_cfg_r;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         master_cfg_r <= icu_pkg::CFG_DEFAULT;
         slave_cfg_r  <= icu_pkg::CFG_DEFAULT;
      end else begin
         master_cfg_r <= master_cfg_nxt;
         slave_cfg_r  <= slave_cfg_nxt;
      end
   end

   // ----------------------------------------------------------------
   // master and slave resolvers
   // ----------------------------------------------------------------
   logic [MN-1:0]  m_pend, m_req, m_force;
   logic           m_any, s_any, m_ack, s_ack;
   logic [MBW-1:0] m_sel;
   logic [EN-1:0]  s_pend;
   logic [SBW-1:0] s_sel;

   // slave request rides the master as a level; cascaded pins are levels too,
   // since an external controller holds its request until acknowledged
   always_comb begin
      m_req   = {s_any, ext_filt_r};
      m_force = {1'b1, {(EN - CN){1'b0}}, cascade_en};
      m_ack   = irq_ack && m_any;
      s_ack   = irq_ack && m_any && m_sel == icu_pkg::SLAVE_IDX;
   end

   prio_resolver #(.N(MN)) u_master (
      .clk         (clk),
      .reset       (reset),
      .req_in      (m_req),
      .edge_mode   (master_cfg_r.edge_mode),
      .force_level (m_force),
      .base        ({1'b0, master_cfg_r.prio_base}),
      .ack         (m_ack),
      .pend_r      (m_pend),
      .any_r       (m_any),
      .sel_r       (m_sel)
   );

   prio_resolver #(.N(icu_pkg::INT_N)) u_slave (
      .clk         (clk),
      .reset       (reset),
      .req_in      (internal_irq_lines),
      .edge_mode   (slave_cfg_r.edge_mode),
      .force_level ('0),
      .base        (slave_cfg_r.prio_base),
      .ack         (s_ack),
      .pend_r      (s_pend),
      .any_r       (s_any),
      .sel_r       (s_sel)
   );

   // ----------------------------------------------------------------
   // core request and acknowledge answer
   // ----------------------------------------------------------------
   logic                 irq_to_core_nxt, ack_valid_nxt;
   icu_pkg::irq_vector_t ack_vector_nxt;
   logic [CN-1:0]        casc_active_nxt;

   // vector holds until the next acknowledge; cascade select is one cycle
   always_comb begin
      irq_to_core_nxt = m_any;
      ack_valid_nxt   = m_ack;
      ack_vector_nxt  = ack_vector_r;
      casc_active_nxt = '0;
      if (m_ack) begin
         if (m_sel == icu_pkg::SLAVE_IDX) begin
            ack_vector_nxt = '{from_slave: 1'b1, line: s_sel};
         end else begin
            ack_vector_nxt = '{from_slave: 1'b0, line: m_sel[SBW-1:0]};
            if (m_sel < MBW'(CN)) begin
               casc_active_nxt = cascade_en & CN'(1 << m_sel);
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_to_core_r <= 1'b0;
         ack_valid_r   <= 1'b0;
         ack_vector_r  <= icu_pkg::VEC_NONE;
         casc_active_r <= '0;
      end else begin
         irq_to_core_r <= irq_to_core_nxt;
         ack_valid_r   <= ack_valid_nxt;
         ack_vector_r  <= ack_vector_nxt;
         casc_active_r <= casc_active_nxt;
      end
   end

   // ----------------------------------------------------------------
   // assertions and cover points
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_core_follows_resolver;
      m_any |=> irq_to_core_r ##1 (irq_to_core_r == $past(m_any));
   endproperty
   a_core_follows_resolver: assert property (p_core_follows_resolver) else $error("core request lost");

   property p_slave_into_master;
      s_any |=> m_pend[icu_pkg::SLAVE_IDX];
   endproperty
   a_slave_into_master: assert property (p_slave_into_master) else $error("slave not seen by master");

   property p_level_latch;
      (!slave_cfg_r.edge_mode && !$past(cfg_wr)) |=> s_pend == $past(internal_irq_lines);
   endproperty
   a_level_latch: assert property (p_level_latch) else $error("level request not latched");

   property p_pin_sync;
      $stable(ext_irq_pins) [*6] |-> ext_filt_r == ext_irq_pins;
   endproperty
   a_pin_sync: assert property (p_pin_sync) else $error("pin not passed after sync");

   property p_default_order;
      (master_cfg_r.prio_base == 3'h0 && $stable(master_cfg_r) && m_pend[0]) |=> m_any && m_sel == '0;
   endproperty
   a_default_order: assert property (p_default_order) else $error("line zero not on top");

   property p_cfg_write;
      cfg_wr |=> master_cfg_r == $past(master_cfg_in) && slave_cfg_r == $past(slave_cfg_in);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("setup write not taken");

   property p_casc_select;
      casc_active_r != '0 |-> ack_valid_r && !ack_vector_r.from_slave
                            && casc_active_r == ($past(cascade_en) & CN'(1 << ack_vector_r.line));
   endproperty
   a_casc_select: assert property (p_casc_select) else $error("wrong cascade select");

   property p_reset_clear;
      $fell(reset) |-> m_pend == '0 && s_pend == '0 && !irq_to_core_r && !ack_valid_r;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");

   property p_rotated_order;
      (m_pend[master_cfg_r.prio_base] && $stable(master_cfg_r)) |=> m_sel == MBW'($past(master_cfg_r.prio_base));
   endproperty
   a_rotated_order: assert property (p_rotated_order) else $error("rotated base not on top");

   c_core_request: cover property (!irq_to_core_r ##1 irq_to_core_r);
   c_slave_ack:    cover property (ack_valid_r && ack_vector_r.from_slave);
   c_casc_ack:     cover property (casc_active_r != '0);
   c_reprogram:    cover property (cfg_wr ##1 master_cfg_r.prio_base != 3'h0);

endmodule

/* File: testbench/core_model.sv */
// processor core model: acknowledges the interrupt request line
module core_model (
   input  wire logic       clk,           // peripheral clock
   input  wire logic       reset,         // synchronous, active high
   input  wire logic       irq_to_core_r, // request from the unit
   input  wire logic       ack_valid_r,   // vector valid pulse
   input  wire logic       auto_ack,      // answer requests when high
   input  wire logic       poke,          // force one acknowledge now
   input  wire logic [3:0] wait_cycles,   // answer latency, prompt or slow
   output logic            irq_ack,       // acknowledge pulse
   output int              ack_seen       // vectors received
);
   timeunit 1ns;
   timeprecision 1ns;

   int cnt;

   // ------------------------------------------------------------
   // acknowledge cycle, stands in for the bus status decode
   // ------------------------------------------------------------
   // quiet gap after each pulse: an edge-mode clear needs 3 cycles to show on a pin, 5 on an internal line
   always @(posedge clk) begin
      if (reset) begin
         irq_ack  <= 1'b0;
         ack_seen <= 0;
         cnt      <= 0;
      end else begin
         if (ack_valid_r) ack_seen <= ack_seen + 1;
         if (irq_ack) begin
            irq_ack <= 1'b0;
            cnt     <= -6;
         end else if (poke) begin
            irq_ack <= 1'b1;  // deliberate ack with nothing selected
         end else if (auto_ack && irq_to_core_r && cnt >= int'(wait_cycles)) begin
            irq_ack <= 1'b1;
         end else begin
            cnt <= (irq_to_core_r || cnt < 0) ? cnt + 1 : 0;
         end
      end
   end
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the cascaded interrupt control unit
module tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk, reset, cfg_wr, irq_ack, auto, poke;
   logic [7:0] pins, lines;
   logic [3:0] casc, dly, casc_active_r, cap_casc;
   icu_pkg::ctrl_cfg_t mcfg, scfg, master_cfg_r, slave_cfg_r;
   icu_pkg::irq_vector_t ack_vector_r, cap_vec;
   logic irq_to_core_r, ack_valid_r;
   int ack_seen, bad_count, compares, cycles, n0;
   logic [31:0] seed;

   irq_control_unit u_irq_control_unit (.clk(clk), .reset(reset), .ext_irq_pins(pins),
      .internal_irq_lines(lines), .cascade_en(casc), .cfg_wr(cfg_wr), .master_cfg_in(mcfg),
      .slave_cfg_in(scfg), .irq_ack(irq_ack), .master_cfg_r(master_cfg_r), .slave_cfg_r(slave_cfg_r),
      .irq_to_core_r(irq_to_core_r), .ack_valid_r(ack_valid_r), .ack_vector_r(ack_vector_r),
      .casc_active_r(casc_active_r));

   core_model u_core_model (.clk(clk), .reset(reset), .irq_to_core_r(irq_to_core_r),
      .ack_valid_r(ack_valid_r), .auto_ack(auto), .poke(poke), .wait_cycles(dly),
      .irq_ack(irq_ack), .ack_seen(ack_seen));

   // ------------------------------------------------------------
   // clock, capture and hang guard
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // cascade select is only meaningful in the valid cycle; the vector holds until the next acknowledge
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (ack_valid_r) begin
         cap_vec  <= ack_vector_r;
         cap_casc <= casc_active_r;
      end
      if (cycles == 5000) begin
         bad_count = bad_count + 1;
         report_and_stop();
      end
   end

   // ------------------------------------------------------------
   // helpers: random source, reference priority, compares
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
   endfunction

   // rotating order: base first, wrapping over n slots
   function automatic int top(input int pend, input int base, input int n);
      for (int i = 0; i < n; i++) if (pend[(base + i) % n]) return (base + i) % n;
      return -1;
   endfunction

   task automatic check_bits(input logic [7:0] got, input logic [7:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED at %0t: bits got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_vec(input icu_pkg::irq_vector_t got, input icu_pkg::irq_vector_t exp);
      compares = compares + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED at %0t: vector got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_ack();
      n0 = ack_seen;
      auto <= 1'b1;
      for (int i = 0; i < 80 && ack_seen == n0; i++) begin
         @(posedge clk);
         #1;
      end
      auto <= 1'b0;
      check_bits(8'(ack_seen != n0), 8'h01);
   endtask

   task automatic set_cfg(input icu_pkg::ctrl_cfg_t m, input icu_pkg::ctrl_cfg_t s);
      @(posedge clk);
      cfg_wr <= 1'b1;
      mcfg   <= m;
      scfg   <= s;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask

   // one level-mode request pattern, acknowledged once
   task automatic run_case(input logic [7:0] p, input logic [7:0] l, input logic [3:0] ce,
                           input logic [2:0] mb, input logic [2:0] sb);
      int m;
      int s;
      icu_pkg::irq_vector_t ev;
      set_cfg('{1'b0, mb}, '{1'b0, sb});
      pins  <= p;
      lines <= l;
      casc  <= ce;
      dly   <= dly ^ 4'h7;
      repeat (12) @(posedge clk);
      #1;
      s = top(int'(l), int'(sb), 8);
      m = top(int'({l != 8'h00, p}), int'(mb), 9);
      check_bits(8'(irq_to_core_r), 8'(m >= 0));
      if (m >= 0) begin
         ev = (m == 8) ? '{1'b1, 3'(s)} : '{1'b0, 3'(m)};
         wait_ack();
         check_vec(cap_vec, ev);
         check_bits(8'(cap_casc), (m < 4 && ce[m]) ? 8'(1 << m) : 8'h00);
      end
      @(posedge clk);
      pins  <= 8'h00;
      lines <= 8'h00;
      repeat (12) @(posedge clk);
   endtask

   // one edge-mode pulse on pins or lines, acknowledged once; pins need 2 cycles to pass the filter
   task automatic edge_case(input logic me, input logic [7:0] p, input logic [7:0] l, input int hold,
                            input icu_pkg::irq_vector_t ev);
      set_cfg('{me, 3'h0}, '{1'b1, 3'h0});
      pins  <= p;
      lines <= l;
      repeat (hold) @(posedge clk);
      pins  <= 8'h00;
      lines <= 8'h00;
      repeat (12) @(posedge clk);
      #1;
      check_bits(8'(irq_to_core_r), 8'h01);
      wait_ack();
      check_vec(cap_vec, ev);
      repeat (10) @(posedge clk);
      #1;
      check_bits(8'(irq_to_core_r), 8'h00);
      @(posedge clk);
   endtask

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1; cfg_wr = 1'b0; auto = 1'b0; poke = 1'b0; dly = 4'h0;
      pins = 8'h00; lines = 8'h00; casc = 4'h0; mcfg = icu_pkg::CFG_DEFAULT;
      scfg = icu_pkg::CFG_DEFAULT; bad_count = 0; compares = 0; cycles = 0;
      seed = 32'hDE53E09C;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      check_bits(8'({irq_to_core_r, ack_valid_r, casc_active_r}), 8'h00);
      check_bits({master_cfg_r, slave_cfg_r}, 8'h00);
      $display("test reset done");

      // every pin and line alone, all low pins carrying a controller
      for (int k = 0; k < 16; k++)
         run_case((k < 8) ? 8'(1 << k) : 8'h00, (k >= 8) ? 8'(1 << (k - 8)) : 8'h00, 4'hF, 3'h0, 3'h0);
      $display("test single lines done");

      // random mixes with random priority rotation
      for (int k = 0; k < 10; k++) begin
         seed = lfsr(seed);
         run_case(seed[7:0], seed[15:8], seed[19:16], (k == 0) ? 3'h0 : seed[22:20], seed[25:23]);
      end
      $display("test priority mixes done");

      // edge mode: a short pulse stays pending until acknowledged, slave then master
      edge_case(1'b0, 8'h00, 8'h20, 1, '{1'b1, 3'h5});
      edge_case(1'b1, 8'h20, 8'h00, 3, '{1'b0, 3'h5});
      // a held line is acknowledged once and must not request again
      lines <= 8'h20;
      repeat (12) @(posedge clk);
      wait_ack();
      check_vec(cap_vec, '{1'b1, 3'h5});
      repeat (10) @(posedge clk);
      #1;
      check_bits(8'(irq_to_core_r), 8'h00);
      $display("test edge mode done");

      // acknowledge with nothing selected is ignored
      @(posedge clk);
      lines <= 8'h00;
      repeat (6) @(posedge clk);
      n0 = ack_seen;
      poke <= 1'b1;
      @(posedge clk);
      poke <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      check_bits(8'(ack_seen - n0), 8'h00);
      $display("test stray acknowledge done");

      // reset in mid-run drops the request and the setup; a held line asks again in level mode
      @(posedge clk);
      lines <= 8'h01;
      repeat (12) @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check_bits(8'({irq_to_core_r, slave_cfg_r}), 8'h00);
      @(posedge clk);
      reset <= 1'b0;
      repeat (12) @(posedge clk);
      #1;
      check_bits(8'(irq_to_core_r), 8'h01);
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule
